/* ceac_pkg.sv */
// Constants for the configuration EEPROM access control block.
// Assumes byte-wide register accesses at the addresses given here.
package ceac_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [11:0] CEAC_OFF_CFG = 12'h500;
  localparam logic [11:0] CEAC_OFF_ACC = 12'h501;
  localparam logic [11:0] CEAC_OFF_CSR = 12'h502;
  localparam logic [11:0] CEAC_OFF_CMD = 12'h503;
  localparam logic [11:0] CEAC_OFF_ADDR = 12'h504;
  localparam logic [11:0] CEAC_OFF_DATA = 12'h508;
  localparam logic [7:0] CEAC_PAGE = 8'h50;

  // ----------------------------------------------------------------------
  // Field positions within the command/status word
  // ----------------------------------------------------------------------
  localparam int CEAC_B_BUSY = 15;
  localparam int CEAC_B_ERR_WE = 14;
  localparam int CEAC_B_ERR_ACK = 13;
  localparam int CEAC_B_LOAD = 12;
  localparam int CEAC_B_CSUM = 11;
  localparam int CEAC_B_CMD = 8;
  localparam int CEAC_B_ALGO = 7;
  localparam int CEAC_B_BYTES8 = 6;
  localparam int CEAC_B_EMUL = 5;
  localparam int CEAC_B_WEN = 0;
  localparam logic CEAC_BYTES8_VAL = 1'b1;

  // ----------------------------------------------------------------------
  // Command codes and address masks
  // ----------------------------------------------------------------------
  localparam logic [2:0] CEAC_CMD_IDLE = 3'h0;
  localparam logic [2:0] CEAC_CMD_READ = 3'h1;
  localparam logic [2:0] CEAC_CMD_WRITE = 3'h2;
  localparam logic [2:0] CEAC_CMD_RELOAD = 3'h4;
  localparam logic [31:0] CEAC_MASK_SMALL = 32'h0000_03ff;
  localparam logic [31:0] CEAC_MASK_LARGE = 32'h0003_ffff;
  localparam logic [31:0] CEAC_ADDR_RST = 32'h0000_0000;
  localparam logic [63:0] CEAC_DATA_RST = 64'h0;
  localparam logic [1:0] CEAC_STRAP_WAIT = 2'h2;

  typedef enum logic [1:0] {CEAC_ST_IDLE, CEAC_ST_ENGINE, CEAC_ST_EMUL} ceac_state_t;

endpackage : ceac_pkg

/* ceac_eeprom_ctrl.sv */
// Command/status, address and data registers of the configuration EEPROM port.
// Assumes a serial bit engine on the same clock and byte-wide register accesses.
//
// Operation
// - Status bit 15 shows busy while a command runs.
// - Bit 14 sets on a write command without write enable.
// - Bit 13 sets on missing acknowledge or an invalid command code.
// - Bit 12 is one while configuration load runs or failed.
// - Bit 11 flags a configuration checksum mismatch.
// - Codes: 000 idle, 001 read, 010 write, 100 reload; others invalid.
// - Writing the command field starts it; reading returns running command.
// - Bit 7 selects one or two address bytes; default from size strap.
// - Bit 6 reports eight bytes per read, always one.
// - Bit 5 shows emulation mode; default from the two emulation straps.
// - Write-enable bit 0 permits writes; cleared at next frame start.
// - Idle code or any valid command clears the error bits.
// - Command field returns to zero when busy drops.
// - New command codes are ignored while bit 13 is pending.
// - Host acknowledge clears the EEPROM event flag.
// - Network side owns the port only when both ownership bits are zero.
// - Address counts words; 10, 18 or 32 bits used by mode.
// - Address and data writes only from the owner; address never while busy, data also while busy in emulation.
// - Data bits 63:16 are read only; 15:0 hold read or write word.
// - Multi-byte registers are little-endian.
// - Host access bit writable only with control bit set and force clear.
`timescale 1ns/1ns
module ceac_eeprom_ctrl (
  input wire logic clock,                // Core clock, 250 MHz.
  input wire logic rst_n,                // Synchronous reset, active low.
  input wire logic reg_wr,               // Byte write strobe.
  input wire logic reg_from_host,        // Access comes from the local host port.
  input wire logic [11:0] reg_addr,      // Byte address.
  input wire logic [7:0] reg_wdata,      // Write byte.
  output logic [7:0] reg_rdata,          // Read byte, one cycle after address.
  input wire logic frame_start,          // Start of a received frame.
  input wire logic load_pending,         // Configuration not loaded or failed.
  input wire logic size_strap,           // Large EEPROM strap pin.
  input wire logic emul_strap_lo,        // Emulation strap pin, low.
  input wire logic emul_strap_hi,        // Emulation strap pin, high.
  input wire logic eng_done,             // Bit engine finished, one pulse.
  input wire logic eng_nack,             // Bit engine saw no acknowledge.
  input wire logic eng_csum_err,         // Reload checksum mismatch.
  input wire logic [63:0] eng_rdata,     // Bit engine read data.
  output logic eng_start,                // Start bit engine, one pulse.
  output logic [2:0] eng_cmd,            // Command for the bit engine.
  output logic [31:0] eng_addr,          // Word address for the bit engine.
  output logic [15:0] eng_wdata,         // Word to be written.
  output logic ee_event                  // EEPROM event flag for the host.
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ceac_pkg::ceac_state_t state_q;
  logic [2:0] cmd_q;
  logic err_we_q, err_ack_q, csum_q, load_q, wen_q;
  logic cfg_ctrl_q, cfg_force_q, acc_taken_q;
  logic algo_q, emul_q;
  logic [1:0] size_s_q, lo_s_q, hi_s_q;
  logic [1:0] strap_cnt_q;
  logic [31:0] addr_q;
  logic [63:0] data_q;
  logic [7:0] rdata_q;
  logic start_q, event_q;
  logic [2:0] eng_cmd_q;
  logic [31:0] eng_addr_q;
  logic [15:0] eng_wdata_q;
  logic busy, host_owns, owner_wr, cmd_wr, wen_ok, issue, start_ok, emul_ack;
  logic [2:0] code;
  logic [127:0] image;

  // Positions of the error flags within the high status byte that a host writes.
  localparam int CEAC_ERR_BYTE = ceac_pkg::CEAC_B_ERR_ACK - 8;
  localparam int CEAC_CSUM_BYTE = ceac_pkg::CEAC_B_CSUM - 8;

  // Valid command codes; everything else except idle is reserved.
  function automatic logic ceac_valid(input logic [2:0] c);
    return c == ceac_pkg::CEAC_CMD_READ || c == ceac_pkg::CEAC_CMD_WRITE ||
           c == ceac_pkg::CEAC_CMD_RELOAD;
  endfunction : ceac_valid

  // Byte write hit at a given address.
  function automatic logic ceac_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : ceac_hit

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Either host bit hands the port to the local host.
  assign host_owns = cfg_ctrl_q | acc_taken_q;
  assign owner_wr = reg_wr && (reg_from_host == host_owns);
  assign busy = state_q != ceac_pkg::CEAC_ST_IDLE;
  assign code = reg_wdata[2:0];
  assign cmd_wr = owner_wr && ceac_hit(reg_addr, ceac_pkg::CEAC_OFF_CMD) && !busy;
  // The local host that owns the port is trusted to write; enable is for the network.
  assign wen_ok = wen_q | host_owns;
  // A pending acknowledge error blocks every code except idle.
  assign issue = cmd_wr && !(err_ack_q && code != ceac_pkg::CEAC_CMD_IDLE);
  assign start_ok = issue && ceac_valid(code) &&
                    !(code == ceac_pkg::CEAC_CMD_WRITE && !wen_ok);
  assign emul_ack = reg_wr && reg_from_host && state_q == ceac_pkg::CEAC_ST_EMUL &&
                    ceac_hit(reg_addr, ceac_pkg::CEAC_OFF_CMD) &&
                    |(code & cmd_q);

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  // Straps are pins: two flops, then loaded on the first two cycles after release and held.
  always_ff @(posedge clock)
  begin
    size_s_q <= {size_s_q[0], size_strap};
    lo_s_q <= {lo_s_q[0], emul_strap_lo};
    hi_s_q <= {hi_s_q[0], emul_strap_hi};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      strap_cnt_q <= 2'h0;
      algo_q <= 1'b0;
      emul_q <= 1'b0;
    end
    else if (strap_cnt_q != ceac_pkg::CEAC_STRAP_WAIT)
    begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      algo_q <= size_s_q[1];
      emul_q <= lo_s_q[1] | hi_s_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // Ownership bits
  // ----------------------------------------------------------------------
  // Force holds the host access bit clear, so the network can reclaim the port.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cfg_ctrl_q <= 1'b0;
      cfg_force_q <= 1'b0;
      acc_taken_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && !reg_from_host && ceac_hit(reg_addr, ceac_pkg::CEAC_OFF_CFG))
      begin
        cfg_ctrl_q <= reg_wdata[0];
        cfg_force_q <= reg_wdata[1];
      end
      if (cfg_force_q)
        acc_taken_q <= 1'b0;
      else if (reg_wr && reg_from_host && cfg_ctrl_q &&
               ceac_hit(reg_addr, ceac_pkg::CEAC_OFF_ACC))
        acc_taken_q <= reg_wdata[0];
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q <= ceac_pkg::CEAC_ST_IDLE;
      cmd_q <= ceac_pkg::CEAC_CMD_IDLE;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      case (state_q)
        ceac_pkg::CEAC_ST_IDLE:
          if (start_ok)
          begin
            cmd_q <= code;
            start_q <= !emul_q;
            state_q <= emul_q ? ceac_pkg::CEAC_ST_EMUL : ceac_pkg::CEAC_ST_ENGINE;
          end
        ceac_pkg::CEAC_ST_ENGINE:
          if (eng_done)
          begin
            cmd_q <= ceac_pkg::CEAC_CMD_IDLE;
            state_q <= ceac_pkg::CEAC_ST_IDLE;
          end
        ceac_pkg::CEAC_ST_EMUL:
          if (emul_ack)
          begin
            cmd_q <= ceac_pkg::CEAC_CMD_IDLE;
            state_q <= ceac_pkg::CEAC_ST_IDLE;
          end
        default:
          state_q <= ceac_pkg::CEAC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Error and status flags
  // ----------------------------------------------------------------------
  // Clears are written first so that a set in the same cycle wins.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      err_we_q <= 1'b0;
      err_ack_q <= 1'b0;
    end
    else
    begin
      if (issue && (code == ceac_pkg::CEAC_CMD_IDLE || ceac_valid(code)))
      begin
        err_we_q <= 1'b0;
        err_ack_q <= 1'b0;
      end
      if (issue && code == ceac_pkg::CEAC_CMD_WRITE && !wen_ok)
        err_we_q <= 1'b1;
      if ((issue && code != ceac_pkg::CEAC_CMD_IDLE && !ceac_valid(code)) ||
          (state_q == ceac_pkg::CEAC_ST_ENGINE && eng_done && eng_nack))
        err_ack_q <= 1'b1;
      if (emul_ack && reg_wdata[CEAC_ERR_BYTE])
        err_ack_q <= 1'b1;
    end
  end

  // Checksum flag follows each reload; the emulating host may set it.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      csum_q <= 1'b0;
      load_q <= 1'b0;
    end
    else
    begin
      load_q <= load_pending;
      if (state_q == ceac_pkg::CEAC_ST_ENGINE && eng_done &&
          cmd_q == ceac_pkg::CEAC_CMD_RELOAD)
        csum_q <= eng_csum_err;
      if (emul_ack && reg_wdata[CEAC_CSUM_BYTE])
        csum_q <= 1'b1;
    end
  end

  // A frame start drops write enable unless the network rewrites it that cycle.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      wen_q <= 1'b0;
    else if (reg_wr && !reg_from_host && ceac_hit(reg_addr, ceac_pkg::CEAC_OFF_CSR))
      wen_q <= reg_wdata[ceac_pkg::CEAC_B_WEN];
    else if (frame_start)
      wen_q <= 1'b0;
  end

  // Event to the local host on each emulated command, dropped by its acknowledge.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      event_q <= 1'b0;
    else if (start_ok && emul_q)
      event_q <= 1'b1;
    else if (emul_ack)
      event_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------------
  // Bytes are little-endian; only the owner writes, and the address never while busy.
  // The emulating host may fill data while busy, since that is how it answers reads.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      addr_q <= ceac_pkg::CEAC_ADDR_RST;
      data_q <= ceac_pkg::CEAC_DATA_RST;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        if (owner_wr && !busy &&
            ceac_hit(reg_addr, ceac_pkg::CEAC_OFF_ADDR + 12'(i)))
          addr_q[8*i +: 8] <= reg_wdata;
      for (int i = 0; i < 2; i++)
        if (owner_wr && (!busy || state_q == ceac_pkg::CEAC_ST_EMUL) &&
            ceac_hit(reg_addr, ceac_pkg::CEAC_OFF_DATA + 12'(i)))
          data_q[8*i +: 8] <= reg_wdata;
      if (state_q == ceac_pkg::CEAC_ST_ENGINE && eng_done && !eng_nack &&
          cmd_q == ceac_pkg::CEAC_CMD_READ)
        data_q <= eng_rdata;
    end
  end

  // Engine request captured at issue; address trimmed to the bits the mode uses.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      eng_cmd_q <= ceac_pkg::CEAC_CMD_IDLE;
      eng_addr_q <= ceac_pkg::CEAC_ADDR_RST;
      eng_wdata_q <= 16'h0000;
    end
    else if (start_ok)
    begin
      eng_cmd_q <= code;
      eng_addr_q <= emul_q ? addr_q : addr_q & (algo_q ? ceac_pkg::CEAC_MASK_LARGE :
                                                 ceac_pkg::CEAC_MASK_SMALL);
      eng_wdata_q <= data_q[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // All sixteen bytes as one little-endian image, lowest address in the low byte.
  assign image = {data_q, addr_q,
                  busy, err_we_q, err_ack_q, load_q, csum_q, cmd_q,
                  algo_q, ceac_pkg::CEAC_BYTES8_VAL, emul_q, 4'h0, wen_q,
                  7'h00, acc_taken_q, 6'h00, cfg_force_q, cfg_ctrl_q};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (reg_addr[11:4] == ceac_pkg::CEAC_PAGE)
      rdata_q <= image[8*reg_addr[3:0] +: 8];
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;
  assign eng_start = start_q;
  assign eng_cmd = eng_cmd_q;
  assign eng_addr = eng_addr_q;
  assign eng_wdata = eng_wdata_q;
  assign ee_event = event_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence seq_engine_done;
    state_q == ceac_pkg::CEAC_ST_ENGINE && eng_done;
  endsequence
  sequence seq_back_idle;
    !busy && cmd_q == ceac_pkg::CEAC_CMD_IDLE;
  endsequence

  chk_start_engine: assert property (eng_start |-> state_q == ceac_pkg::CEAC_ST_ENGINE &&
                                     cmd_q == eng_cmd)
    else $error("engine start without matching command");
  chk_write_noen: assert property (issue && code == ceac_pkg::CEAC_CMD_WRITE && !wen_ok
                                   |=> err_we_q && !busy)
    else $error("write without enable not flagged");
  chk_nack_flag: assert property (seq_engine_done and eng_nack |=> err_ack_q)
    else $error("missing acknowledge not flagged");
  chk_done_clear: assert property (seq_engine_done |=> seq_back_idle)
    else $error("command field not cleared after completion");
  chk_pending_block: assert property (err_ack_q && cmd_wr && code != 3'h0
                                      |=> !busy ##1 !eng_start)
    else $error("command accepted while error pending");
  chk_wen_frame: assert property (frame_start && !(reg_wr && !reg_from_host)
                                  |=> !wen_q)
    else $error("write enable survived frame start");
  chk_ack_event: assert property (emul_ack |=> (!ee_event) and seq_back_idle)
    else $error("acknowledge did not clear event");
  chk_busy_hold: assert property (busy && state_q != ceac_pkg::CEAC_ST_EMUL
                                  |=> $stable(data_q[15:0]) || $past(eng_done))
    else $error("data changed while busy");
  chk_bytes_bit: assert property (reg_addr == ceac_pkg::CEAC_OFF_CSR
                                  |=> reg_rdata[ceac_pkg::CEAC_B_BYTES8])
    else $error("byte count bit not one");

endmodule : ceac_eeprom_ctrl

/* ceac_engine_model.sv */
// Behavioural serial bit engine facing the EEPROM control block.
// Assumes the core clock and the start/done handshake of the control block.
`timescale 1ns/1ns
module ceac_engine_model (
  input wire logic clock,           // Core clock.
  input wire logic rst_n,           // Synchronous reset, active low.
  input wire logic eng_start,       // Start pulse from the block.
  input wire logic [31:0] eng_addr, // Word address from the block.
  input wire logic [7:0] eng_delay, // Cycles a command takes.
  input wire logic nack_req,        // Answer the next command without acknowledge.
  input wire logic csum_req,        // Report a checksum mismatch on the next command.
  output logic eng_done,            // Command finished, one pulse.
  output logic eng_nack,            // No acknowledge, valid with done.
  output logic eng_csum_err,        // Checksum mismatch, valid with done.
  output logic [63:0] eng_rdata     // Read data, valid with done.
);
  logic busy_q;
  logic done_q;
  logic nack_q;
  logic csum_q;
  logic [7:0] cnt_q;
  logic [31:0] addr_q;
  logic [63:0] churn_q;

  // --------------------------------------------------------------------
  // Command timing
  // --------------------------------------------------------------------
  // Qualifiers are latched at start, so the bench may move its requests meanwhile.
  always_ff @(posedge clock)
  begin
    churn_q <= {churn_q[62:0], ~churn_q[63]};
    done_q <= 1'b0;
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      churn_q <= 64'h0;
    end
    else if (eng_start)
    begin
      busy_q <= 1'b1;
      cnt_q <= eng_delay;
      addr_q <= eng_addr;
      nack_q <= nack_req;
      csum_q <= csum_req;
    end
    else if (busy_q)
    begin
      busy_q <= (cnt_q > 8'h01);
      done_q <= (cnt_q <= 8'h01);
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // Outside done the qualifiers churn, so a late or early sample sees garbage.
  assign eng_done = done_q;
  assign eng_nack = done_q ? nack_q : churn_q[0];
  assign eng_csum_err = done_q ? csum_q : churn_q[1];
  assign eng_rdata = done_q ? ({4{addr_q[15:0]}} ^ 64'h0123_4567_89ab_cdef) : churn_q;
endmodule : ceac_engine_model

/* ceac_eeprom_ctrl_tb_top.sv */
// Self-checking bench for the EEPROM control block with an engine model.
// Assumes byte register accesses and the package constants of the block.
`timescale 1ns/1ns
module ceac_eeprom_ctrl_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_from_host = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic frame_start = 1'b0;
  logic load_pending = 1'b1;
  logic size_strap = 1'b1;
  logic emul_strap_lo = 1'b0;
  logic emul_strap_hi = 1'b0;
  logic nack_req = 1'b0;
  logic csum_req = 1'b0;
  logic [7:0] eng_delay = 8'h0c;
  logic [7:0] reg_rdata;
  logic eng_start, eng_done, eng_nack, eng_csum_err, ee_event;
  logic [2:0] eng_cmd;
  logic [31:0] eng_addr;
  logic [15:0] eng_wdata;
  logic [63:0] eng_rdata;
  logic rd_v = 1'b0;
  logic rd_v1 = 1'b0;
  logic [7:0] rd_q[$];
  logic [50:0] iss_q[$];
  logic [7:0] bad [4] = '{8'h03, 8'h05, 8'h06, 8'h07};
  logic [31:0] a;
  logic [31:0] m;
  logic [63:0] d;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 3;
  int i;

  ceac_eeprom_ctrl u_dut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_from_host(reg_from_host), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_start(frame_start), .load_pending(load_pending),
    .size_strap(size_strap), .emul_strap_lo(emul_strap_lo), .emul_strap_hi(emul_strap_hi),
    .eng_done(eng_done), .eng_nack(eng_nack), .eng_csum_err(eng_csum_err),
    .eng_rdata(eng_rdata), .eng_start(eng_start), .eng_cmd(eng_cmd), .eng_addr(eng_addr),
    .eng_wdata(eng_wdata), .ee_event(ee_event));

  ceac_engine_model u_eng (.clock(clock), .rst_n(rst_n), .eng_start(eng_start),
    .eng_addr(eng_addr), .eng_delay(eng_delay), .nack_req(nack_req), .csum_req(csum_req),
    .eng_done(eng_done), .eng_nack(eng_nack), .eng_csum_err(eng_csum_err),
    .eng_rdata(eng_rdata));

  // Free-running 250 MHz core clock.
  initial
  begin
    forever #2 clock = ~clock;
  end

  // --------------------------------------------------------------------
  // Checking and reporting
  // --------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // --------------------------------------------------------------------
  // Bus driver; every task is entered just after a rising edge
  // --------------------------------------------------------------------
  task automatic wr(input logic host, input logic [11:0] adr, input logic [7:0] dat);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_from_host <= host;
    reg_addr <= adr;
    reg_wdata <= dat;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] adr, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= adr;
    rd_v <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clock);
    rd_v <= 1'b0;
  endtask : rd

  // Done is sampled as the block sees it; busy has dropped one edge later.
  task automatic wait_done();
    int n;
    for (n = 0; n < 200 && eng_done !== 1'b1; n++) @(posedge clock);
    if (eng_done !== 1'b1)
    begin
      error_cnt++;
      stop_test();
    end
    @(posedge clock);
  endtask : wait_done

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : do_reset

  // Watcher: each read answer and each engine start takes the oldest note.
  always @(posedge clock)
  begin
    rd_v1 <= rd_v;
    if (rd_v1 && rd_q.size() > 0)
    begin
      chk({56'h0, reg_rdata}, {56'h0, rd_q.pop_front()});
    end
    if (eng_start === 1'b1 && iss_q.size() == 0)
    begin
      chk(64'h1, 64'h0);
    end
    else if (eng_start === 1'b1)
    begin
      chk({13'h0, eng_cmd, eng_addr, eng_wdata}, {13'h0, iss_q.pop_front()});
    end
  end

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial
  begin
    do_reset();
    rd(12'h502, 8'hc0);
    rd(12'h503, 8'h10);
    load_pending <= 1'b0;
    rd(12'h503, 8'h00);
    for (i = 0; i < 12; i++) rd(12'h504 + 12'(i), 8'h00);
    rd(12'h7f0, 8'h00);
    // Read with a random address; two address bytes, so 18 bits reach the engine.
    a = $random(seed);
    m = a & ceac_pkg::CEAC_MASK_LARGE;
    d = {4{a[15:0]}} ^ 64'h0123_4567_89ab_cdef;
    for (i = 0; i < 4; i++) wr(1'b0, 12'h504 + 12'(i), a[8*i+:8]);
    for (i = 0; i < 4; i++) rd(12'h504 + 12'(i), a[8*i+:8]);
    iss_q.push_back({ceac_pkg::CEAC_CMD_READ, m, 16'h0000});
    wr(1'b0, 12'h503, 8'h01);
    rd(12'h503, 8'h81);
    wr(1'b0, 12'h504, 8'hff);
    wait_done();
    rd(12'h503, 8'h00);
    rd(12'h504, a[7:0]);
    for (i = 0; i < 8; i++) rd(12'h508 + 12'(i), d[8*i+:8]);
    wr(1'b0, 12'h503, 8'h02);
    rd(12'h503, 8'h40);
    wr(1'b0, 12'h503, 8'h00);
    rd(12'h503, 8'h00);
    // Write with enable and a prompt engine; upper data stays read only.
    eng_delay <= 8'h01;
    wr(1'b0, 12'h503, 8'h02);
    rd(12'h503, 8'h40);
    wr(1'b0, 12'h502, 8'h01);
    rd(12'h502, 8'hc1);
    wr(1'b0, 12'h508, 8'h5a);
    wr(1'b0, 12'h509, 8'ha5);
    wr(1'b0, 12'h50a, 8'hee);
    iss_q.push_back({ceac_pkg::CEAC_CMD_WRITE, m, 16'ha55a});
    wr(1'b0, 12'h503, 8'h02);
    wait_done();
    rd(12'h503, 8'h00);
    rd(12'h50a, d[23:16]);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    rd(12'h502, 8'hc0);
    // Reserved codes latch the error, which blocks a new command until idle is written.
    for (i = 0; i < 4; i++)
    begin
      wr(1'b0, 12'h503, bad[i]);
      rd(12'h503, 8'h20);
      wr(1'b0, 12'h503, 8'h01);
      rd(12'h503, 8'h20);
      wr(1'b0, 12'h503, 8'h00);
      rd(12'h503, 8'h00);
    end
    eng_delay <= 8'h0c;
    nack_req <= 1'b1;
    iss_q.push_back({ceac_pkg::CEAC_CMD_READ, m, 16'ha55a});
    wr(1'b0, 12'h503, 8'h01);
    wait_done();
    rd(12'h503, 8'h20);
    nack_req <= 1'b0;
    wr(1'b0, 12'h503, 8'h00);
    csum_req <= 1'b1;
    iss_q.push_back({ceac_pkg::CEAC_CMD_RELOAD, m, 16'ha55a});
    wr(1'b0, 12'h503, 8'h04);
    wait_done();
    rd(12'h503, 8'h08);
    csum_req <= 1'b0;
    // Ownership moves to the host and back by the force bit.
    wr(1'b1, 12'h501, 8'h01);
    rd(12'h501, 8'h00);
    wr(1'b0, 12'h500, 8'h01);
    wr(1'b1, 12'h501, 8'h01);
    rd(12'h501, 8'h01);
    wr(1'b0, 12'h504, 8'h77);
    wr(1'b1, 12'h504, 8'h66);
    rd(12'h504, 8'h66);
    wr(1'b0, 12'h500, 8'h02);
    rd(12'h501, 8'h00);
    wr(1'b0, 12'h504, 8'h55);
    rd(12'h504, 8'h55);
    // Emulation: the host owns the port and answers commands itself.
    emul_strap_hi <= 1'b1;
    size_strap <= 1'b0;
    do_reset();
    rd(12'h502, 8'h60);
    wr(1'b0, 12'h500, 8'h01);
    wr(1'b1, 12'h501, 8'h01);
    wr(1'b1, 12'h503, 8'h01);
    @(posedge clock);
    chk({63'h0, ee_event}, 64'h1);
    rd(12'h503, 8'h81);
    wr(1'b1, 12'h508, 8'h3c);
    wr(1'b1, 12'h503, 8'h01);
    rd(12'h503, 8'h00);
    chk({63'h0, ee_event}, 64'h0);
    rd(12'h508, 8'h3c);
    wr(1'b1, 12'h503, 8'h01);
    wr(1'b1, 12'h503, 8'h21);
    rd(12'h503, 8'h20);
    // A host checksum report rides on the acknowledge and outlives it.
    wr(1'b1, 12'h503, 8'h00);
    wr(1'b1, 12'h503, 8'h01);
    wr(1'b1, 12'h503, 8'h09);
    rd(12'h503, 8'h08);
    // Normal mode with one address byte: only ten address bits reach the engine.
    emul_strap_hi <= 1'b0;
    do_reset();
    rd(12'h502, 8'h40);
    for (i = 0; i < 4; i++) wr(1'b0, 12'h504 + 12'(i), a[8*i+:8]);
    m = a & ceac_pkg::CEAC_MASK_SMALL;
    iss_q.push_back({ceac_pkg::CEAC_CMD_READ, m, 16'h0000});
    wr(1'b0, 12'h503, 8'h01);
    wait_done();
    rd(12'h503, 8'h00);
    repeat (4) @(posedge clock);
    stop_test();
  end
endmodule : ceac_eeprom_ctrl_tb_top
